//--- ubs_pkg.sv
// Purpose: constants for the baud divider and sync slave transmitter
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: register offsets are word aligned
package ubs_pkg;
	localparam logic [7:0] UBS_ADR_CTRL = 8'h00;
	localparam logic [7:0] UBS_ADR_DIV_LO = 8'h04;
	localparam logic [7:0] UBS_ADR_DIV_HI = 8'h08;
	localparam logic [7:0] UBS_ADR_TXDATA = 8'h0C;
	localparam logic [7:0] UBS_ADR_STAT = 8'h10;
	localparam logic [7:0] UBS_ADR_IMASK = 8'h14;
	// control register bit positions
	localparam int UBS_B_SYNC = 0;
	localparam int UBS_B_CLOCK_SOURCE_SEL = 1;
	localparam int UBS_B_SINGLE_RECEIVE_EN = 2;
	localparam int UBS_B_CONTINUOUS_RECEIVE_EN = 3;
	localparam int UBS_B_SERIAL_PORT_EN = 4;
	localparam int UBS_B_TRANSMIT_EN = 5;
	localparam int UBS_B_TX9 = 6;
	localparam int UBS_B_NINTH_TX_BIT = 7;
	localparam int UBS_B_HIGH_SPEED_SEL = 8;
	localparam int UBS_B_WIDE = 9;
	localparam int UBS_B_PERIPHERAL_INT_EN = 10;
	localparam int UBS_B_TX_INT_EN = 11;
	localparam int UBS_B_GIE = 12;
	localparam int UBS_CTRL_W = 13;
	// status bit positions
	localparam int UBS_S_TX_INT_FLAG = 0;
	localparam int UBS_S_TICK = 1;
	localparam int UBS_S_DONE = 2;
	localparam logic [12:0] UBS_CTRL_RST = 13'h0000;
	localparam logic [2:0] UBS_STAT_RST = 3'h0;
	localparam logic [15:0] UBS_DIV_RST = 16'h0000;
	localparam logic [5:0] UBS_MUL_ASYNC_LO8 = 6'h3F;
	localparam logic [5:0] UBS_MUL_ASYNC_HI8 = 6'h0F;
	localparam logic [5:0] UBS_MUL_SYNC = 6'h03;
	localparam logic [3:0] UBS_BITS_8 = 4'h8;
	localparam logic [3:0] UBS_BITS_9 = 4'h9;
endpackage

//--- ubs_brg.sv
// Purpose: free running baud divider with prescale multiplier
// Assumes: divisor and modes steady between writes
// Notes: tick_o pulses once per baud period
`timescale 1ns/1ps
`default_nettype none
module ubs_brg
	import ubs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clr_i,
	input wire logic wide_i,
	input wire logic high_speed_sel_i,
	input wire logic sync_i,
	input wire logic [15:0] div_i,
	output logic tick_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic [5:0] pre;
		logic tick;
	} ubs_brg_st_t;
	ubs_brg_st_t st_r, st_nxt;
	logic [5:0] pre_max;
	logic [15:0] top;
	always_comb begin
		// multiplier: sync fixed, async set by high_speed_sel and width
		if (sync_i)
			pre_max = UBS_MUL_SYNC;
		else if (wide_i)
			pre_max = high_speed_sel_i ? UBS_MUL_SYNC : UBS_MUL_ASYNC_HI8;
		else
			pre_max = high_speed_sel_i ? UBS_MUL_ASYNC_HI8 : UBS_MUL_ASYNC_LO8;
		top = wide_i ? div_i : {8'h00, div_i[7:0]};
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (clr_i) begin
			st_nxt.cnt = 16'h0000;
			st_nxt.pre = 6'h00;
		end else if (st_r.pre >= pre_max) begin
			st_nxt.pre = 6'h00;
			if (st_r.cnt >= top) begin
				st_nxt.cnt = 16'h0000;
				st_nxt.tick = 1'b1;
			end else
				st_nxt.cnt = st_r.cnt + 16'h0001;
		end else
			st_nxt.pre = st_r.pre + 6'h01;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign tick_o = st_r.tick;
endmodule
`default_nettype wire

//--- ubs_top.sv
// Purpose: baud divider and synchronous slave transmitter
// Assumes: wishbone classic slave; sync clock pin is asynchronous
// Notes: data shifts on falling sync clock, lsb first
//
// What this block does
// - divider is 8-bit after reset, 16-bit when wide select set
// - divisor high and low pair sets the baud timer period in 16-bit mode, low byte alone in 8-bit mode
// - async multiplier depends on high speed and wide select together
// - sync mode ignores the high speed select
// - writing either divisor byte clears the baud timer at once
// - async 8-bit low speed rate is clock over 64 times divisor plus one
// - transmit when both receive enables clear, else receive
// - slave transmit acts as master transmit except in sleep
// - in sleep first word shifts out, second waits, flag clear from the second write on
// - after first word, second moves to shifter and flag sets in the same cycle
// - flag wakes device when enables set; vectors if global enable
`timescale 1ns/1ps
`default_nettype none
module ubs_top
	import ubs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sleep_i,
	input wire logic sync_clock_pin_i,
	output logic tx_data_o,
	output logic tx_data_oe_o,
	output logic baud_tick_o,
	output logic wake_o,
	output logic vector_o,
	output logic irq_o
);
	typedef struct packed {
		logic [12:0] ctrl;
		logic [15:0] div;
		logic [8:0] hold;
		logic hold_full;
		logic [8:0] shift;
		logic [3:0] nbits;
		logic busy;
		logic tx_int_flag;
		logic [2:0] stat;
		logic [2:0] mask;
		logic [1:0] ck_sync;
		logic ck_prev;
		logic txd;
		logic txoe;
		logic ack;
		logic [31:0] rdat;
		logic tick;
		logic wake;
		logic vec;
		logic irq;
	} ubs_st_t;
	ubs_st_t st_r, st_nxt;
	logic brg_tick;
	logic brg_clr;
	logic wr;
	logic rd;
	logic ck_fall;
	logic tx_mode;
	logic slave_on;
	logic [2:0] ev;
	logic pend;
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic en);
		merge8 = en ? nw : old;
	endfunction
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_r.ack;
	assign brg_clr = wr && wb_sel_i[0] && (wb_adr_i == UBS_ADR_DIV_LO || wb_adr_i == UBS_ADR_DIV_HI);
	ubs_brg u_brg (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clr_i(brg_clr),
		.wide_i(st_r.ctrl[UBS_B_WIDE]),
		.high_speed_sel_i(st_r.ctrl[UBS_B_HIGH_SPEED_SEL]),
		.sync_i(st_r.ctrl[UBS_B_SYNC]),
		.div_i(st_r.div),
		.tick_o(brg_tick)
	);
	always_comb begin
		st_nxt = st_r;
		ev = 3'h0;
		st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
		st_nxt.ck_sync = {st_r.ck_sync[0], sync_clock_pin_i};
		st_nxt.ck_prev = st_r.ck_sync[1];
		ck_fall = st_r.ck_prev && !st_r.ck_sync[1];
		slave_on = st_r.ctrl[UBS_B_SYNC] && !st_r.ctrl[UBS_B_CLOCK_SOURCE_SEL] && st_r.ctrl[UBS_B_SERIAL_PORT_EN];
		tx_mode = !st_r.ctrl[UBS_B_SINGLE_RECEIVE_EN] && !st_r.ctrl[UBS_B_CONTINUOUS_RECEIVE_EN];
		st_nxt.tick = brg_tick;
		ev[UBS_S_TICK] = brg_tick;
		if (wr) begin
			unique case (wb_adr_i)
				UBS_ADR_CTRL: begin
					st_nxt.ctrl[7:0] = merge8(st_r.ctrl[7:0], wb_dat_i[7:0], wb_sel_i[0]);
					if (wb_sel_i[1])
						st_nxt.ctrl[12:8] = wb_dat_i[12:8];
				end
				UBS_ADR_DIV_LO: st_nxt.div[7:0] = merge8(st_r.div[7:0], wb_dat_i[7:0], wb_sel_i[0]);
				UBS_ADR_DIV_HI: st_nxt.div[15:8] = merge8(st_r.div[15:8], wb_dat_i[7:0], wb_sel_i[0]);
				UBS_ADR_TXDATA: begin
					if (wb_sel_i[0] && !st_r.hold_full) begin
						st_nxt.hold = {st_r.ctrl[UBS_B_NINTH_TX_BIT], wb_dat_i[7:0]};
						st_nxt.hold_full = 1'b1;
						st_nxt.tx_int_flag = 1'b0;
					end
				end
				UBS_ADR_IMASK: if (wb_sel_i[0]) st_nxt.mask = wb_dat_i[2:0];
				default: ;
			endcase
		end
		if (wr && wb_adr_i == UBS_ADR_STAT && wb_sel_i[0])
			st_nxt.stat = st_r.stat & ~wb_dat_i[2:0];
		// shifter driven by external clock edges only
		if (slave_on && tx_mode && st_r.ctrl[UBS_B_TRANSMIT_EN]) begin
			st_nxt.txoe = 1'b1;
			if (st_r.busy && ck_fall) begin
				st_nxt.txd = st_r.shift[0];
				st_nxt.shift = {1'b0, st_r.shift[8:1]};
				st_nxt.nbits = st_r.nbits - 4'h1;
				if (st_r.nbits == 4'h1) begin
					st_nxt.busy = 1'b0;
					ev[UBS_S_DONE] = 1'b1;
				end
			end
			if (st_nxt.hold_full && !st_nxt.busy) begin
				st_nxt.shift = st_nxt.hold;
				st_nxt.nbits = st_r.ctrl[UBS_B_TX9] ? UBS_BITS_9 : UBS_BITS_8;
				st_nxt.busy = 1'b1;
				st_nxt.hold_full = 1'b0;
			end
		end else begin
			st_nxt.txoe = 1'b0;
			st_nxt.busy = 1'b0;
			st_nxt.txd = 1'b1;
		end
		// flag rises only once holding reg is empty again
		if (!st_nxt.hold_full && (st_r.hold_full || !st_r.tx_int_flag) && st_r.ctrl[UBS_B_TRANSMIT_EN])
			st_nxt.tx_int_flag = 1'b1;
		ev[UBS_S_TX_INT_FLAG] = st_nxt.tx_int_flag && !st_r.tx_int_flag;
		st_nxt.stat = st_nxt.stat | ev;
		pend = st_r.tx_int_flag && st_r.ctrl[UBS_B_TX_INT_EN] && st_r.ctrl[UBS_B_PERIPHERAL_INT_EN];
		st_nxt.wake = pend && sleep_i;
		st_nxt.vec = pend && st_r.ctrl[UBS_B_GIE];
		st_nxt.irq = |(st_r.stat & st_r.mask);
		st_nxt.rdat = 32'h0000_0000;
		if (rd) begin
			unique case (wb_adr_i)
				UBS_ADR_CTRL: st_nxt.rdat = {19'h0_0000, st_r.ctrl};
				UBS_ADR_DIV_LO: st_nxt.rdat = {24'h00_0000, st_r.div[7:0]};
				UBS_ADR_DIV_HI: st_nxt.rdat = {24'h00_0000, st_r.div[15:8]};
				UBS_ADR_TXDATA: st_nxt.rdat = {22'h00_0000, st_r.busy, st_r.hold_full, st_r.hold[7:0]};
				UBS_ADR_STAT: st_nxt.rdat = {28'h000_0000, st_r.tx_int_flag, st_r.stat};
				UBS_ADR_IMASK: st_nxt.rdat = {29'h0000_0000, st_r.mask};
				default: st_nxt.rdat = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '0;
			st_r.ctrl <= UBS_CTRL_RST;
			st_r.div <= UBS_DIV_RST;
			st_r.stat <= UBS_STAT_RST;
			st_r.txd <= 1'b1;
			st_r.ck_prev <= 1'b1;
			st_r.ck_sync <= 2'b11;
		end else
			st_r <= st_nxt;
	end
	assign wb_dat_o = st_r.rdat;
	assign wb_ack_o = st_r.ack;
	assign tx_data_o = st_r.txd;
	assign tx_data_oe_o = st_r.txoe;
	assign baud_tick_o = st_r.tick;
	assign wake_o = st_r.wake;
	assign vector_o = st_r.vec;
	assign irq_o = st_r.irq;

	logic shift_on;
	assign shift_on = slave_on && tx_mode && st_r.ctrl[UBS_B_TRANSMIT_EN];
	logic last_fall;
	assign last_fall = shift_on && st_r.busy && ck_fall && st_r.nbits == 4'h1;

	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i)
			wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

	property p_ack_req;
		@(posedge clk_i) disable iff (rst_i)
			(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("no ack after request");

	property p_rdat_idle;
		@(posedge clk_i) disable iff (rst_i)
			!wb_ack_o |-> (wb_dat_o == 32'h0000_0000);
	endproperty
	a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside ack");

	property p_div_clr;
		@(posedge clk_i) disable iff (rst_i)
			brg_clr |=> !brg_tick;
	endproperty
	a_div_clr: assert property (p_div_clr) else $error("tick right after divisor write");

	property p_div_keep;
		@(posedge clk_i) disable iff (rst_i)
			!wr |=> $stable(st_r.div);
	endproperty
	a_div_keep: assert property (p_div_keep) else $error("divisor changed without write");

	property p_div_lo_wr;
		@(posedge clk_i) disable iff (rst_i)
			(wr && wb_adr_i == UBS_ADR_DIV_LO && wb_sel_i[0]) |=> (st_r.div[7:0] == $past(wb_dat_i[7:0]));
	endproperty
	a_div_lo_wr: assert property (p_div_lo_wr) else $error("divisor low byte not written");

	property p_div_hi_wr;
		@(posedge clk_i) disable iff (rst_i)
			(wr && wb_adr_i == UBS_ADR_DIV_HI && wb_sel_i[0]) |=> (st_r.div[15:8] == $past(wb_dat_i[7:0]));
	endproperty
	a_div_hi_wr: assert property (p_div_hi_wr) else $error("divisor high byte not written");

	property p_ctrl_keep;
		@(posedge clk_i) disable iff (rst_i)
			!wr |=> $stable(st_r.ctrl);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("control changed without write");

	property p_tick_single;
		@(posedge clk_i) disable iff (rst_i)
			baud_tick_o |=> !baud_tick_o;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("baud tick longer than one cycle");

	property p_rx_quiet;
		@(posedge clk_i) disable iff (rst_i)
			!tx_mode |=> !st_r.busy;
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("shifting in receive direction");

	property p_oe_on;
		@(posedge clk_i) disable iff (rst_i)
			shift_on |=> tx_data_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("data pin not driven in slave transmit");

	property p_oe_off;
		@(posedge clk_i) disable iff (rst_i)
			!shift_on |=> (!tx_data_oe_o && tx_data_o);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("data pin driven outside slave transmit");

	property p_fall_bit;
		@(posedge clk_i) disable iff (rst_i)
			(shift_on && st_r.busy && ck_fall) |=> (tx_data_o == $past(st_r.shift[0]));
	endproperty
	a_fall_bit: assert property (p_fall_bit) else $error("wrong bit after clock fall");

	property p_shift_edge;
		@(posedge clk_i) disable iff (rst_i)
			(st_r.busy && !ck_fall) |=> $stable(st_r.nbits);
	endproperty
	a_shift_edge: assert property (p_shift_edge) else $error("bit count moved without clock fall");

	property p_bit_hold;
		@(posedge clk_i) disable iff (rst_i)
			(shift_on && st_r.busy && !ck_fall) |=> $stable(tx_data_o);
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("data bit changed between falls");

	property p_nbits_range;
		@(posedge clk_i) disable iff (rst_i)
			st_r.busy |-> (st_r.nbits != 4'h0 && st_r.nbits <= UBS_BITS_9);
	endproperty
	a_nbits_range: assert property (p_nbits_range) else $error("bit count out of range");

	property p_last_bit;
		@(posedge clk_i) disable iff (rst_i)
			(last_fall && !st_r.hold_full && !wr) |=> !st_r.busy;
	endproperty
	a_last_bit: assert property (p_last_bit) else $error("shifter busy after last bit");

	property p_second_load;
		@(posedge clk_i) disable iff (rst_i)
			(last_fall && st_r.hold_full) |=> (st_r.busy && !st_r.hold_full && st_r.tx_int_flag);
	endproperty
	a_second_load: assert property (p_second_load) else $error("second word not moved or flag clear");

	property p_tx_load;
		@(posedge clk_i) disable iff (rst_i)
			(shift_on && !st_r.busy && st_r.hold_full) |=> st_r.busy;
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("word not moved to shifter");

	property p_hold_flag;
		@(posedge clk_i) disable iff (rst_i)
			st_r.hold_full |-> !st_r.tx_int_flag;
	endproperty
	a_hold_flag: assert property (p_hold_flag) else $error("flag set with full holding reg");

	property p_stat_keep;
		@(posedge clk_i) disable iff (rst_i)
			!(wr && wb_adr_i == UBS_ADR_STAT) |=> ((st_r.stat & $past(st_r.stat)) == $past(st_r.stat));
	endproperty
	a_stat_keep: assert property (p_stat_keep) else $error("status bit lost without clear");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
			(|(st_r.stat & st_r.mask)) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	property p_wake;
		@(posedge clk_i) disable iff (rst_i)
			(sleep_i && st_r.tx_int_flag && st_r.ctrl[UBS_B_TX_INT_EN] && st_r.ctrl[UBS_B_PERIPHERAL_INT_EN]) |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on flag");

	property p_wake_sleep;
		@(posedge clk_i) disable iff (rst_i)
			wake_o |-> $past(sleep_i);
	endproperty
	a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");

	property p_vec;
		@(posedge clk_i) disable iff (rst_i)
			vector_o |-> $past(st_r.ctrl[UBS_B_GIE]);
	endproperty
	a_vec: assert property (p_vec) else $error("vector without global enable");

	property p_vec_pend;
		@(posedge clk_i) disable iff (rst_i)
			vector_o |-> $past(st_r.tx_int_flag && st_r.ctrl[UBS_B_TX_INT_EN] && st_r.ctrl[UBS_B_PERIPHERAL_INT_EN]);
	endproperty
	a_vec_pend: assert property (p_vec_pend) else $error("vector without pending flag");

	c_done: cover property (@(posedge clk_i) ev[UBS_S_DONE]);
	c_two_words: cover property (@(posedge clk_i) st_r.busy && st_r.hold_full && sleep_i);
	c_wake: cover property (@(posedge clk_i) wake_o);
	c_ninth: cover property (@(posedge clk_i) ev[UBS_S_DONE] && st_r.ctrl[UBS_B_TX9]);
	c_vec: cover property (@(posedge clk_i) vector_o);
endmodule
`default_nettype wire

//--- ubs_sync_master.sv
// Purpose: external synchronous master that clocks the slave transmitter
// Assumes: slave moves data after a falling clock, master samples before rising
// Notes: clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module ubs_sync_master (
	input wire logic clk_i,
	input wire logic data_i,
	output logic pin_o,
	output logic [8:0] word_o
);
	initial begin
		pin_o = 1'b1;
		word_o = 9'h000;
	end
	// one frame, lsb first, half period in system clocks
	task automatic frame(input int nbits, input int half);
		word_o = 9'h000;
		for (int i = 0; i < nbits; i++) begin
			@(posedge clk_i);
			pin_o <= 1'b0;
			repeat (half) @(posedge clk_i);
			word_o[i] = data_i;
			pin_o <= 1'b1;
			repeat (half) @(posedge clk_i);
		end
	endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the baud divider and sync slave transmitter
// Assumes: bus answers with a one-cycle ack
// Notes: expected words come from a queue model
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import ubs_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic sleep = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rd;
	logic [31:0] dat_o;
	logic ack, pin, txd, oe, tick, wake, vec, irq;
	logic [8:0] word;
	int num_errors = 0;
	int num_checks = 0;
	int q[$];
	int d, e, n, c;
	localparam int C_TX = (1 << UBS_B_SYNC) | (1 << UBS_B_SERIAL_PORT_EN) | (1 << UBS_B_TRANSMIT_EN) | (1 << UBS_B_PERIPHERAL_INT_EN) |
		(1 << UBS_B_TX_INT_EN) | (1 << UBS_B_GIE);
	always #12.5 clk_i = ~clk_i;
	ubs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_i(sleep),
		.sync_clock_pin_i(pin), .tx_data_o(txd), .tx_data_oe_o(oe), .baud_tick_o(tick), .wake_o(wake),
		.vector_o(vec), .irq_o(irq));
	ubs_sync_master i_mst (.clk_i(clk_i), .data_i(txd), .pin_o(pin), .word_o(word));
	task chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		chk(ack, 1);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task wait_tick;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (tick !== 1'b1 && n < 9000);
	endtask
	task test_done;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk_i);
		num_errors++;
		test_done();
	end
	initial begin
		void'($urandom(91329));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({txd, oe, irq, wake, vec, tick}, 6'h20);
		bus(0, 8'h1C, 32'h0000_0000);
		chk(rd, 0);
		// every async multiplier pair, then sync with high speed set
		for (int m = 0; m < 5; m++) begin
			d = $urandom_range(3);
			c = (m[1] ? 1 << UBS_B_WIDE : 0) | ((m[0] || m == 4) ? 1 << UBS_B_HIGH_SPEED_SEL : 0);
			c = c | (m == 4 ? 1 << UBS_B_SYNC : 0);
			e = m == 4 ? 4 : m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64);
			bus(1, UBS_ADR_CTRL, c);
			bus(1, UBS_ADR_DIV_HI, 1);
			bus(1, UBS_ADR_DIV_LO, d);
			wait_tick();
			wait_tick();
			chk(n, e * ((m[1] ? 256 : 0) + d + 1));
		end
		// slow rate, then a new divisor mid count
		bus(1, UBS_ADR_CTRL, 0);
		bus(1, UBS_ADR_DIV_LO, 200);
		repeat (500) @(posedge clk_i);
		d = $urandom_range(3);
		bus(1, UBS_ADR_DIV_LO, d);
		wait_tick();
		chk(n > 64 * (d + 1) - 4 && n < 64 * (d + 1) + 4, 1);
		bus(1, UBS_ADR_IMASK, 1 << UBS_S_TX_INT_FLAG);
		for (int k = 0; k < 2; k++) begin
			e = $urandom_range(1);
			bus(1, UBS_ADR_CTRL, C_TX | k << UBS_B_TX9 | e << UBS_B_NINTH_TX_BIT);
			sleep <= 1'b1;
			for (int j = 0; j < 2; j++) begin
				d = $urandom_range(255);
				q.push_back(k ? (e << 8 | d) : d);
				bus(1, UBS_ADR_TXDATA, d);
			end
			bus(1, UBS_ADR_STAT, 32'h0000_0007);
			bus(0, UBS_ADR_STAT, 0);
			chk({rd[3], wake, irq}, 3'h0);
			chk(oe, 1);
			i_mst.frame(8 + k, 5);
			chk(word, q.pop_front());
			repeat (8) @(posedge clk_i);
			bus(0, UBS_ADR_STAT, 0);
			chk(rd[3], 1);
			chk({wake, vec, irq}, 3'h7);
			i_mst.frame(8 + k, 9);
			chk(word, q.pop_front());
			bus(1, UBS_ADR_STAT, 32'h0000_0007);
			sleep <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk({wake, irq}, 2'h0);
		end
		// tick event masked, then unmasked
		bus(1, UBS_ADR_IMASK, 0);
		wait_tick();
		repeat (2) @(posedge clk_i);
		chk(irq, 0);
		bus(1, UBS_ADR_IMASK, 1 << UBS_S_TICK);
		repeat (2) @(posedge clk_i);
		chk(irq, 1);
		bus(1, UBS_ADR_TXDATA, 8'h5A);
		for (int b = UBS_B_SINGLE_RECEIVE_EN; b <= UBS_B_CONTINUOUS_RECEIVE_EN; b++) begin
			bus(1, UBS_ADR_CTRL, C_TX | 1 << b);
			repeat (2) @(posedge clk_i);
			chk(oe, 0);
		end
		test_done();
	end
endmodule
`default_nettype wire
